// ===== verilog/seil_pkg.sv
`default_nettype none
package seil_pkg;

    // ****************************************
    // register word indices on the avalon bus
    // ****************************************
    localparam logic [3:0] SEIL_IDX_ALERT_CFG = 4'h0;
    localparam logic [3:0] SEIL_IDX_EVENT_ENABLE = 4'h1;
    localparam logic [3:0] SEIL_IDX_EVENT_MODE_ONE = 4'h2;
    localparam logic [3:0] SEIL_IDX_EVENT_MODE_TWO = 4'h3;
    localparam logic [3:0] SEIL_IDX_EVENT_FLAGS = 4'h4;
    localparam logic [3:0] SEIL_IDX_PROX_CH1_TH = 4'h5;
    localparam logic [3:0] SEIL_IDX_PROX_CH2_TH = 4'h6;
    localparam logic [3:0] SEIL_IDX_PROX_CH3_TH = 4'h7;
    localparam logic [3:0] SEIL_IDX_PROX_HYST = 4'h8;
    localparam logic [3:0] SEIL_IDX_PROX_HISTORY = 4'h9;
    localparam logic [3:0] SEIL_IDX_AMB_LOW_TH = 4'ha;
    localparam logic [3:0] SEIL_IDX_AMB_HIGH_TH = 4'hb;
    localparam logic [3:0] SEIL_IDX_AMB_HYST = 4'hc;
    localparam logic [3:0] SEIL_IDX_AMB_HISTORY = 4'hd;
    localparam logic [3:0] SEIL_IDX_MONITOR = 4'he;

    // ****************************************
    // field positions, widths and channel counts
    // ****************************************
    localparam int SEIL_CFG_OE_BIT = 0;
    localparam int SEIL_CFG_CLRMODE_BIT = 1;
    localparam int SEIL_EN_PROX_LSB = 2;
    localparam int SEIL_MODE1_AMB_LSB = 0;
    localparam int SEIL_MODE1_PROX1_LSB = 4;
    localparam int SEIL_MODE1_PROX2_LSB = 6;
    localparam int SEIL_MODE2_PROX3_LSB = 0;
    localparam int SEIL_HIST_CNT_W = 3;
    localparam int SEIL_NUM_CH = 5;
    localparam int SEIL_NUM_PROX = 3;
    localparam int SEIL_VAL_W = 21;

    // ****************************************
    // encodings and reset values
    // ****************************************
    localparam logic [1:0] SEIL_PMODE_EVERY = 2'h0;
    localparam logic [1:0] SEIL_PMODE_CROSS = 2'h1;
    localparam logic [1:0] SEIL_PMODE_ABOVE = 2'h3;
    localparam logic [1:0] SEIL_CFG_RST = 2'h0;
    localparam logic [4:0] SEIL_EN_RST = 5'h00;
    localparam logic [7:0] SEIL_BYTE_RST = 8'h00;

    typedef struct packed {
        logic [1:0] alert_cfg;
        logic [4:0] evt_en;
        logic [7:0] mode_one;
        logic [1:0] mode_two;
        logic [4:0] evt_flags;
        logic [2:0][7:0] prox_th;
        logic [7:0] prox_hyst;
        logic [7:0] prox_hist;
        logic [7:0] amb_lo;
        logic [7:0] amb_hi;
        logic [7:0] amb_hyst;
        logic [7:0] amb_hist;
        logic [4:0] mon;
        logic [4:0][2:0] hist_cnt;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
        logic alert_oe;
        logic alert_n;
    } seil_state_t;

endpackage
`default_nettype wire

// ===== verilog/seil_top.sv
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`default_nettype none
module seil_top
    import seil_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [2:0] i_prox_result_valid,
    input wire logic [15:0] i_prox_ch1_result,
    input wire logic [15:0] i_prox_ch2_result,
    input wire logic [15:0] i_prox_ch3_result,
    input wire logic i_ambient_visible_valid,
    input wire logic [15:0] i_ambient_visible_result,
    input wire logic i_ambient_infrared_valid,
    input wire logic [15:0] i_ambient_infrared_result,
    output logic o_irq,
    output logic o_alert_oe,
    output logic o_alert_n
);

    // ****************************************
    // helpers
    // ****************************************
    // compressed byte: high nibble exponent, low nibble mantissa with hidden one when the exponent is nonzero
    function automatic logic [SEIL_VAL_W-1:0] decode_thr(input logic [7:0] c);
        logic [SEIL_VAL_W-1:0] v;
        v = '0;
        if (c[7:4] == 4'h0) begin
            v = {{(SEIL_VAL_W-4){1'b0}}, c[3:0]};
        end else begin
            v = {{(SEIL_VAL_W-5){1'b0}}, 1'b1, c[3:0]} << (c[7:4] - 4'h1);
        end
        return v;
    endfunction

    function automatic logic [7:0] read_reg(input seil_state_t s, input logic [3:0] idx);
        logic [7:0] r;
        r = 8'h00;
        case (idx)
            SEIL_IDX_ALERT_CFG: r = {6'h00, s.alert_cfg};
            SEIL_IDX_EVENT_ENABLE: r = {3'h0, s.evt_en};
            SEIL_IDX_EVENT_MODE_ONE: r = s.mode_one;
            SEIL_IDX_EVENT_MODE_TWO: r = {6'h00, s.mode_two};
            SEIL_IDX_EVENT_FLAGS: r = {3'h0, s.evt_flags};
            SEIL_IDX_PROX_CH1_TH: r = s.prox_th[0];
            SEIL_IDX_PROX_CH2_TH: r = s.prox_th[1];
            SEIL_IDX_PROX_CH3_TH: r = s.prox_th[2];
            SEIL_IDX_PROX_HYST: r = s.prox_hyst;
            SEIL_IDX_PROX_HISTORY: r = s.prox_hist;
            SEIL_IDX_AMB_LOW_TH: r = s.amb_lo;
            SEIL_IDX_AMB_HIGH_TH: r = s.amb_hi;
            SEIL_IDX_AMB_HYST: r = s.amb_hyst;
            SEIL_IDX_AMB_HISTORY: r = s.amb_hist;
            SEIL_IDX_MONITOR: r = {3'h0, s.mon};
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    seil_state_t q;
    seil_state_t d;

    // ****************************************
    // channel views
    // ****************************************
    logic [4:0] ch_valid;
    logic [4:0][SEIL_VAL_W-1:0] ch_val;
    logic [2:0][1:0] prox_mode;

    assign ch_valid = {i_ambient_infrared_valid, i_ambient_visible_valid, i_prox_result_valid};
    assign ch_val[0] = {5'h00, i_prox_ch1_result};
    assign ch_val[1] = {5'h00, i_prox_ch2_result};
    assign ch_val[2] = {5'h00, i_prox_ch3_result};
    assign ch_val[3] = {5'h00, i_ambient_visible_result};
    assign ch_val[4] = {5'h00, i_ambient_infrared_result};
    assign prox_mode[0] = q.mode_one[SEIL_MODE1_PROX1_LSB +: 2];
    assign prox_mode[1] = q.mode_one[SEIL_MODE1_PROX2_LSB +: 2];
    assign prox_mode[2] = q.mode_two[SEIL_MODE2_PROX3_LSB +: 2];

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [SEIL_VAL_W-1:0] th;
        logic [SEIL_VAL_W-1:0] lo;
        logic [SEIL_VAL_W-1:0] hi;
        logic [SEIL_VAL_W-1:0] hy;
        logic [2:0] hn;
        logic flip;
        logic [4:0] crossed;
        logic [4:0] set_evt;
        logic [4:0] clr;
        logic [1:0] amb_en;
        logic [2:0] amb_mode;
        logic wr_go;
        logic rd_go;
        th = '0;
        lo = decode_thr(q.amb_lo);
        hi = decode_thr(q.amb_hi);
        hy = '0;
        hn = 3'h0;
        flip = 1'b0;
        crossed = 5'h00;
        set_evt = 5'h00;
        clr = 5'h00;
        amb_en = q.evt_en[1:0];
        amb_mode = q.mode_one[SEIL_MODE1_AMB_LSB +: 3];
        d = q;

        // the request is held until waitrequest drops; read data is captured at that edge, a write or clear only at the next edge
        wr_go = i_avs_write && !q.waitreq;
        rd_go = i_avs_read && !q.waitreq;
        d.waitreq = !((i_avs_read || i_avs_write) && q.waitreq);
        if (i_avs_read && q.waitreq) begin
            d.rdata = {24'h000000, read_reg(q, i_avs_address)};
        end

        // ****************************************
        // threshold state with hysteresis and history
        // ****************************************
        for (int c = 0; c < SEIL_NUM_CH; c++) begin
            if (c < SEIL_NUM_PROX) begin
                th = decode_thr(q.prox_th[c]);
                hy = decode_thr(q.prox_hyst);
                hn = q.prox_hist[SEIL_HIST_CNT_W-1:0];
                flip = q.mon[c] ? ((ch_val[c] + hy) < th) : (ch_val[c] > (th + hy));
            end else begin
                hy = decode_thr(q.amb_hyst);
                hn = q.amb_hist[SEIL_HIST_CNT_W-1:0];
                flip = q.mon[c] ? (((ch_val[c] + hy) < lo) || (ch_val[c] > (hi + hy)))
                                : ((ch_val[c] >= (lo + hy)) && ((ch_val[c] + hy) <= hi));
            end
            // a change of side must persist for history+1 samples, which rejects single glitches when history is 1 or more
            if (ch_valid[c]) begin
                if (!flip) begin
                    d.hist_cnt[c] = 3'h0;
                end else if (q.hist_cnt[c] == hn) begin
                    d.hist_cnt[c] = 3'h0;
                    d.mon[c] = !q.mon[c];
                    crossed[c] = 1'b1;
                end else begin
                    d.hist_cnt[c] = 3'(q.hist_cnt[c] + 3'h1);
                end
            end
        end

        // ****************************************
        // proximity events
        // ****************************************
        for (int p = 0; p < SEIL_NUM_PROX; p++) begin
            if (q.evt_en[SEIL_EN_PROX_LSB + p] && ch_valid[p]) begin
                case (prox_mode[p])
                    SEIL_PMODE_EVERY: set_evt[SEIL_EN_PROX_LSB + p] = 1'b1;
                    SEIL_PMODE_CROSS: set_evt[SEIL_EN_PROX_LSB + p] = crossed[p];
                    SEIL_PMODE_ABOVE: set_evt[SEIL_EN_PROX_LSB + p] = d.mon[p];
                    default: set_evt[SEIL_EN_PROX_LSB + p] = 1'b0;
                endcase
            end
        end

        // ****************************************
        // ambient events
        // ****************************************
        // visible per sample
        if (amb_en == 2'h1 && amb_mode == 3'h0 && ch_valid[3]) begin
            set_evt[0] = 1'b1;
        end
        if (amb_en[0] && amb_mode[1:0] == 2'h1 && crossed[3] && !d.mon[3]) begin
            set_evt[0] = 1'b1;
        end
        if (amb_en[1] && amb_mode[2:1] == 2'h2 && crossed[3] && d.mon[3]) begin
            set_evt[1] = 1'b1;
        end
        if (amb_en[0] && amb_mode[1:0] == 2'h3 && crossed[4] && !d.mon[4]) begin
            set_evt[0] = 1'b1;
        end
        if (amb_en[1] && amb_mode[2:1] == 2'h3 && crossed[4] && d.mon[4]) begin
            set_evt[1] = 1'b1;
        end
        // infrared samples alone never pulse flag 0 per sample

        // ****************************************
        // register writes
        // ****************************************
        if (wr_go && i_avs_byteenable[0]) begin
            case (i_avs_address)
                SEIL_IDX_ALERT_CFG: d.alert_cfg = i_avs_writedata[1:0];
                SEIL_IDX_EVENT_ENABLE: d.evt_en = i_avs_writedata[4:0];
                SEIL_IDX_EVENT_MODE_ONE: d.mode_one = i_avs_writedata[7:0];
                SEIL_IDX_EVENT_MODE_TWO: d.mode_two = i_avs_writedata[1:0];
                SEIL_IDX_EVENT_FLAGS: clr = i_avs_writedata[4:0];
                SEIL_IDX_PROX_CH1_TH: d.prox_th[0] = i_avs_writedata[7:0];
                SEIL_IDX_PROX_CH2_TH: d.prox_th[1] = i_avs_writedata[7:0];
                SEIL_IDX_PROX_CH3_TH: d.prox_th[2] = i_avs_writedata[7:0];
                SEIL_IDX_PROX_HYST: d.prox_hyst = i_avs_writedata[7:0];
                SEIL_IDX_PROX_HISTORY: d.prox_hist = i_avs_writedata[7:0];
                SEIL_IDX_AMB_LOW_TH: d.amb_lo = i_avs_writedata[7:0];
                SEIL_IDX_AMB_HIGH_TH: d.amb_hi = i_avs_writedata[7:0];
                SEIL_IDX_AMB_HYST: d.amb_hyst = i_avs_writedata[7:0];
                SEIL_IDX_AMB_HISTORY: d.amb_hist = i_avs_writedata[7:0];
                default: clr = 5'h00;
            endcase
        end
        // clear mode 1: the flags held in the cycle a read of the flags completes are cleared as well
        if (rd_go && q.alert_cfg[SEIL_CFG_CLRMODE_BIT] && i_avs_address == SEIL_IDX_EVENT_FLAGS) begin
            clr = clr | q.evt_flags;
        end

        d.evt_flags = (q.evt_flags & ~clr) | set_evt;

        // ****************************************
        // interrupt and alert pin
        // ****************************************
        // mask and flags
        d.irq = |(d.evt_en & d.evt_flags);
        d.alert_oe = d.irq && d.alert_cfg[SEIL_CFG_OE_BIT];
        d.alert_n = !d.alert_oe;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            q.alert_cfg <= SEIL_CFG_RST;
            q.evt_en <= SEIL_EN_RST;
            q.mode_one <= SEIL_BYTE_RST;
            q.mode_two <= 2'h0;
            q.evt_flags <= 5'h00;
            q.prox_th <= '0;
            q.prox_hyst <= SEIL_BYTE_RST;
            q.prox_hist <= SEIL_BYTE_RST;
            q.amb_lo <= SEIL_BYTE_RST;
            q.amb_hi <= SEIL_BYTE_RST;
            q.amb_hyst <= SEIL_BYTE_RST;
            q.amb_hist <= SEIL_BYTE_RST;
            q.mon <= 5'h00;
            q.hist_cnt <= '0;
            q.waitreq <= 1'b1;
            q.rdata <= 32'h00000000;
            q.irq <= 1'b0;
            q.alert_oe <= 1'b0;
            q.alert_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign o_avs_readdata = q.rdata;
    assign o_avs_waitrequest = q.waitreq;
    assign o_irq = q.irq;
    assign o_alert_oe = q.alert_oe;
    assign o_alert_n = q.alert_n;

endmodule
`default_nettype wire

// ===== sim/seil_top_sva.sv
`default_nettype none
module seil_top_sva (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic [2:0] i_prox_result_valid,
    input wire logic i_ambient_visible_valid,
    input wire logic i_ambient_infrared_valid,
    input wire logic o_irq,
    input wire logic o_alert_oe,
    input wire logic o_alert_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    logic done;
    logic smp;
    // only a completed bus access may clear flags or change the mask
    assign done = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
    assign smp = (|i_prox_result_valid) || i_ambient_visible_valid || i_ambient_infrared_valid;
    sequence req_taken;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence one_wait;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence
    // ****************************************
    // assertions
    // ****************************************
    bus_accept_a: assert property (req_taken |=> one_wait)
        else $error("bus request not answered after one wait cycle");
    wait_idle_a: assert property (!o_avs_waitrequest |-> $past(i_avs_read || i_avs_write))
        else $error("waitrequest low without a request");
    pin_polarity_a: assert property (o_alert_n == !o_alert_oe)
        else $error("alert level does not follow its enable");
    pin_gate_a: assert property (o_alert_oe |-> o_irq)
        else $error("alert driven with no pending event");
    pin_release_a: assert property ($fell(o_alert_oe) |-> $past(done))
        else $error("alert released without a bus access");
    irq_cause_a: assert property ($rose(o_irq) |-> $past(smp || done))
        else $error("interrupt rose without sample or access");
    oe_cause_a: assert property ($rose(o_alert_oe) |-> $past(smp || done))
        else $error("alert rose without sample or access");
    irq_sticky_a: assert property (o_irq && !done |=> o_irq)
        else $error("interrupt dropped without a host access");
endmodule
bind seil_top seil_top_sva u_sva (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .i_prox_result_valid(i_prox_result_valid),
    .i_ambient_visible_valid(i_ambient_visible_valid), .i_ambient_infrared_valid(i_ambient_infrared_valid),
    .o_irq(o_irq), .o_alert_oe(o_alert_oe), .o_alert_n(o_alert_n));
`default_nettype wire

// ===== sim/seil_host.sv
`default_nettype none
module seil_host
    import seil_pkg::*;
(
    input wire logic i_clk_sys,
    output logic [3:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata,
    output logic [3:0] o_byteenable,
    input wire logic [31:0] i_readdata,
    input wire logic i_waitrequest
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_address = 4'h0;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h0000_0000;
        o_byteenable = 4'h1;
    end
    // ****************************************
    // bus cycles
    // ****************************************
    // released write data is inverted so a stale value is never mistaken for live data
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_address <= a;
        o_writedata <= {24'h00_0000, d};
        o_write <= 1'b1;
        do @(posedge i_clk_sys); while (i_waitrequest !== 1'b0);
        o_write <= 1'b0;
        o_writedata <= ~{24'h00_0000, d};
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        o_address <= a;
        o_read <= 1'b1;
        do @(posedge i_clk_sys); while (i_waitrequest !== 1'b0);
        d = i_readdata;
        o_read <= 1'b0;
    endtask
    task automatic clear_all();
        logic [31:0] v;
        rd(SEIL_IDX_EVENT_FLAGS, v);
        wr(SEIL_IDX_EVENT_FLAGS, v[7:0]);
    endtask
endmodule
`default_nettype wire

// ===== sim/sensor_event_interrupt_logic_test.sv
`default_nettype none
module sensor_event_interrupt_logic_test import seil_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [4:0] en;
        logic [7:0] m1;
        logic [1:0] m2;
        logic [2:0] ch;
        logic [15:0] v0;
        logic [15:0] v1;
        logic [4:0] fl;
    } seil_row_t;
    logic clk = 1'b0;
    logic rst, rd_s, wr_s, wq, irq, oe, an, vv, vr;
    logic [3:0] addr, be;
    logic [31:0] wdata, rdata, d;
    logic [2:0] pv;
    logic [15:0] smp;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    // ****************************************
    // ordinary cases: enable, mode one, mode two, channel, two samples, flags
    // ****************************************
    seil_row_t rows [18] = '{
        '{5'h04, 8'h00, 2'h0, 3'h0, 16'h0000, 16'h0000, 5'h04}, '{5'h00, 8'h00, 2'h0, 3'h0, 16'h0000, 16'h0000, 5'h00},
        '{5'h04, 8'h10, 2'h0, 3'h0, 16'h0000, 16'h0064, 5'h04}, '{5'h04, 8'h30, 2'h0, 3'h0, 16'h0064, 16'h0064, 5'h04},
        '{5'h04, 8'h20, 2'h0, 3'h0, 16'h0000, 16'h0064, 5'h00}, '{5'h08, 8'h00, 2'h0, 3'h1, 16'h0000, 16'h0000, 5'h08},
        '{5'h08, 8'hc0, 2'h0, 3'h1, 16'h0064, 16'h0064, 5'h08}, '{5'h08, 8'hc0, 2'h0, 3'h1, 16'h0000, 16'h0000, 5'h00},
        '{5'h10, 8'h00, 2'h0, 3'h2, 16'h0000, 16'h0000, 5'h10}, '{5'h10, 8'h00, 2'h1, 3'h2, 16'h0000, 16'h0064, 5'h10},
        '{5'h10, 8'h00, 2'h3, 3'h2, 16'h0064, 16'h0064, 5'h10}, '{5'h01, 8'h00, 2'h0, 3'h3, 16'h0000, 16'h0000, 5'h01},
        '{5'h00, 8'h00, 2'h0, 3'h3, 16'h0000, 16'h0000, 5'h00}, '{5'h01, 8'h00, 2'h0, 3'h4, 16'h0000, 16'h0000, 5'h00},
        '{5'h01, 8'h01, 2'h0, 3'h3, 16'h000f, 16'h001e, 5'h01}, '{5'h02, 8'h04, 2'h0, 3'h3, 16'h001e, 16'h000f, 5'h02},
        '{5'h01, 8'h03, 2'h0, 3'h4, 16'h000f, 16'h001e, 5'h01}, '{5'h02, 8'h06, 2'h0, 3'h4, 16'h001e, 16'h000f, 5'h02}};
    always #5 clk = ~clk;
    seil_host host (.i_clk_sys(clk), .o_address(addr), .o_read(rd_s), .o_write(wr_s), .o_writedata(wdata),
        .o_byteenable(be), .i_readdata(rdata), .i_waitrequest(wq));
    seil_top DUT (.i_clk_sys(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd_s), .i_avs_write(wr_s),
        .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wq),
        .i_prox_result_valid(pv), .i_prox_ch1_result(smp), .i_prox_ch2_result(smp), .i_prox_ch3_result(smp),
        .i_ambient_visible_valid(vv), .i_ambient_visible_result(smp), .i_ambient_infrared_valid(vr),
        .i_ambient_infrared_result(smp), .o_irq(irq), .o_alert_oe(oe), .o_alert_n(an));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one sample pulse, then one cycle for the flag to show
    task automatic sample(input logic [2:0] ch, input logic [15:0] v);
        @(posedge clk);
        smp <= v;
        pv <= (ch < 3'h3) ? 3'(1 << ch) : 3'h0;
        vv <= (ch == 3'h3);
        vr <= (ch == 3'h4);
        @(posedge clk);
        pv <= 3'h0;
        vv <= 1'b0;
        vr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        rst = 1'b1;
        pv = 3'h0;
        vv = 1'b0;
        vr = 1'b0;
        smp = 16'h0000;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("reset waitrequest", 32'h1, 32'(wq));
        chk("reset alert_n", 32'h1, 32'(an));
        chk("reset irq", 32'h0, 32'(irq));
        chk("reset alert_oe", 32'h0, 32'(oe));
        host.rd(SEIL_IDX_ALERT_CFG, d);
        chk("reset cfg", 32'h0, d);
        host.rd(4'hf, d);
        chk("unmapped read", 32'h0, d);
        host.wr(SEIL_IDX_PROX_CH1_TH, 8'h05);
        host.wr(SEIL_IDX_PROX_CH2_TH, 8'h05);
        host.wr(SEIL_IDX_PROX_CH3_TH, 8'h05);
        host.wr(SEIL_IDX_AMB_LOW_TH, 8'h0a);
        host.wr(SEIL_IDX_AMB_HIGH_TH, 8'h14);
        host.wr(SEIL_IDX_ALERT_CFG, 8'h01);
        foreach (rows[i]) begin
            host.wr(SEIL_IDX_EVENT_ENABLE, {3'h0, rows[i].en});
            host.wr(SEIL_IDX_EVENT_MODE_ONE, rows[i].m1);
            host.wr(SEIL_IDX_EVENT_MODE_TWO, {6'h00, rows[i].m2});
            sample(rows[i].ch, rows[i].v0);
            host.clear_all();
            sample(rows[i].ch, rows[i].v1);
            host.rd(SEIL_IDX_EVENT_FLAGS, d);
            chk("row flags", {27'h0, rows[i].fl}, d);
            chk("row alert_n", 32'(!(|rows[i].fl)), 32'(an));
            host.wr(SEIL_IDX_EVENT_FLAGS, 8'h1f);
        end
        // ****************************************
        // awkward cases
        // ****************************************
        host.wr(SEIL_IDX_EVENT_MODE_ONE, 8'h00);
        host.wr(SEIL_IDX_EVENT_ENABLE, 8'h0c);
        sample(3'h0, 16'h0000);
        sample(3'h1, 16'h0000);
        host.wr(SEIL_IDX_EVENT_ENABLE, 8'h00);
        @(posedge clk);
        chk("masked irq", 32'h0, 32'(irq));
        host.wr(SEIL_IDX_EVENT_FLAGS, 8'h00);
        host.rd(SEIL_IDX_EVENT_FLAGS, d);
        chk("flags after zero write", 32'h0c, d);
        host.wr(SEIL_IDX_EVENT_FLAGS, 8'h04);
        host.rd(SEIL_IDX_EVENT_FLAGS, d);
        chk("flags after partial clear", 32'h08, d);
        host.wr(SEIL_IDX_EVENT_ENABLE, 8'h0c);
        host.wr(SEIL_IDX_ALERT_CFG, 8'h00);
        @(posedge clk);
        chk("pin enable off", 32'h0, 32'(oe));
        chk("irq with pin off", 32'h1, 32'(irq));
        host.wr(SEIL_IDX_ALERT_CFG, 8'h01);
        @(posedge clk);
        chk("pin asserted", 32'h0, 32'(an));
        fork
            host.wr(SEIL_IDX_EVENT_FLAGS, 8'h0c);
            begin
                @(posedge clk);
                sample(3'h1, 16'h0000);
            end
        join
        host.rd(SEIL_IDX_EVENT_FLAGS, d);
        chk("set beats clear", 32'h08, d);
        host.clear_all();
        @(posedge clk);
        chk("irq after clear", 32'h0, 32'(irq));
        // hysteresis of 2 and history of 1: 6 stays below, 8 must be seen twice before it counts
        host.wr(SEIL_IDX_PROX_HYST, 8'h02);
        host.wr(SEIL_IDX_PROX_HISTORY, 8'h01);
        host.wr(SEIL_IDX_EVENT_ENABLE, 8'h04);
        host.wr(SEIL_IDX_EVENT_MODE_ONE, 8'h10);
        sample(3'h0, 16'h0006);
        sample(3'h0, 16'h0008);
        host.rd(SEIL_IDX_EVENT_FLAGS, d);
        chk("one sample past history", 32'h0, d);
        sample(3'h0, 16'h0008);
        host.rd(SEIL_IDX_EVENT_FLAGS, d);
        chk("crossing after history", 32'h04, d);
        host.rd(SEIL_IDX_MONITOR, d);
        chk("monitor state", 32'h1d, d);
        // clear mode 1: a completed read of the flags clears the flags held as it completes
        host.wr(SEIL_IDX_ALERT_CFG, 8'h03);
        host.rd(SEIL_IDX_EVENT_FLAGS, d);
        chk("read in clear mode", 32'h04, d);
        host.rd(SEIL_IDX_EVENT_FLAGS, d);
        chk("flags cleared by read", 32'h0, d);
        host.wr(SEIL_IDX_ALERT_CFG, 8'h01);
        // second reset in mid-run with an event pending
        host.wr(SEIL_IDX_EVENT_MODE_ONE, 8'h00);
        sample(3'h0, 16'h0000);
        chk("irq before reset", 32'h1, 32'(irq));
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("reset irq again", 32'h0, 32'(irq));
        chk("reset alert_oe again", 32'h0, 32'(oe));
        chk("reset alert_n again", 32'h1, 32'(an));
        host.rd(SEIL_IDX_EVENT_FLAGS, d);
        chk("reset flags", 32'h0, d);
        host.rd(SEIL_IDX_PROX_HISTORY, d);
        chk("reset history", 32'h0, d);
        stop_test();
    end
endmodule
`default_nettype wire
